// ### common/rsq_map.svh
`ifndef RSQ_MAP_SVH
`define RSQ_MAP_SVH

// ==========================================================
// Clock and timing
`define RSQ_CLK_HZ 40000000
`define RSQ_RELEASE_DELAY_MS 100
`define RSQ_RELEASE_DELAY_CYC (`RSQ_RELEASE_DELAY_MS * (`RSQ_CLK_HZ / 1000))
`define RSQ_QUALIFY_US 100
`define RSQ_QUALIFY_CYC ((`RSQ_QUALIFY_US * (`RSQ_CLK_HZ / 1000) + 999) / 1000)
`define RSQ_STARTUP_LONG_CYC 1024
`define RSQ_STARTUP_SHORT_CYC 2

// ==========================================================
// Register offsets (byte addresses)
`define RSQ_CFG_OFS 4'h0
`define RSQ_STAT_OFS 4'h4
`define RSQ_CTRL_OFS 4'h8

// ==========================================================
// Field positions
`define RSQ_CFG_LOW_EN 0
`define RSQ_CFG_THR_LSB 1
`define RSQ_CFG_OSC_LSB 3
`define RSQ_CFG_STARTUP_SHORT 5
`define RSQ_STAT_TO 0
`define RSQ_STAT_PD 1
`define RSQ_STAT_LOW 2
`define RSQ_STAT_CAUSE_LSB 3
`define RSQ_STAT_BUSY 6
`define RSQ_CTRL_HALT 0

// ==========================================================
// Reset values
`define RSQ_CFG_RST 6'h01

`endif

// ### common/rsq_pkg.sv
package rsq_pkg;

	typedef enum logic [4:0]
	{
		ST_RUN = 5'h01,
		ST_HOLD = 5'h02,
		ST_DELAY = 5'h04,
		ST_STARTUP = 5'h08,
		ST_INIT = 5'h10
	} rsq_state_e;

	typedef enum logic [2:0]
	{
		CAUSE_NONE = 3'h0,
		CAUSE_POR = 3'h1,
		CAUSE_PIN = 3'h2,
		CAUSE_LOW = 3'h3,
		CAUSE_WDT = 3'h4,
		CAUSE_WDT_IDLE = 3'h5
	} rsq_cause_e;

	typedef enum logic [1:0]
	{
		OSC_EXT_RC = 2'h0,
		OSC_INT_RC = 2'h1,
		OSC_FAST_XTAL = 2'h2,
		OSC_SLOW_XTAL = 2'h3
	} rsq_osc_e;

endpackage

// ### src/rsq_sync2.sv
`timescale 1ns/1ps

module rsq_sync2 #(
	parameter logic RST_VAL = 1'b0
)
(
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic async_in,
	output logic sync_out
);

	logic meta_ff;
	logic sync_ff;

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end
		else
		begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;

endmodule

// ### src/rsq_count.sv
`timescale 1ns/1ps

module rsq_count #(
	parameter int W = 8
)
(
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic clr_in,
	input wire logic en_in,
	input wire logic [W-1:0] limit_in,
	output logic done_out
);

	logic [W-1:0] cnt_ff;

	// Saturates at the limit so done stays up while enabled
	always_ff @(posedge mclk_in)
	begin
		if (srst_in || clr_in)
			cnt_ff <= '0;
		else if (en_in && (cnt_ff != limit_in))
			cnt_ff <= cnt_ff + 1'b1;
	end

	assign done_out = (cnt_ff == limit_in);

endmodule

// ### src/rsq_top.sv
`timescale 1ns/1ps
`include "rsq_map.svh"

module rsq_top #(
	parameter int RELEASE_DELAY_CYC = `RSQ_RELEASE_DELAY_CYC,
	parameter int QUALIFY_CYC = `RSQ_QUALIFY_CYC
)
(
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic ext_reset_pin_n_in,
	input wire logic low_supply_in,
	input wire logic wdt_timeout_in,
	input wire logic sleep_mode_in,
	input wire logic [3:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	output logic [1:0] low_supply_threshold_out,
	output logic low_supply_enable_out,
	output logic core_reset_out,
	output logic pc_zero_out,
	output logic sp_zero_out,
	output logic sp_top_out,
	output logic irq_disable_out,
	output logic wdt_clear_out,
	output logic timer_off_out,
	output logic prescaler_clear_out,
	output logic io_input_out,
	output logic wake_out,
	output logic timeout_flag_out,
	output logic power_down_flag_out
);

	localparam int TW = 23;
	localparam logic [TW-1:0] DELAY_LIM = TW'(RELEASE_DELAY_CYC - 1);
	localparam logic [TW-1:0] STARTUP_LONG_LIM = TW'(`RSQ_STARTUP_LONG_CYC - 1);
	localparam logic [TW-1:0] STARTUP_SHORT_LIM = TW'(`RSQ_STARTUP_SHORT_CYC - 1);
	localparam int QW = 16;
	localparam logic [QW-1:0] QUAL_LIM = QW'(QUALIFY_CYC);

	// ==========================================================
	// Declarations
	rsq_pkg::rsq_state_e state_ff;
	rsq_pkg::rsq_state_e nxt_state;
	rsq_pkg::rsq_cause_e cause_ff;
	rsq_pkg::rsq_osc_e osc_sel;
	logic [5:0] cfg_ff;
	logic full_ff;
	logic por_ff;
	logic hold_ff;
	logic pin_n_sync;
	logic low_sync;
	logic pin_low;
	logic low_qual_done;
	logic low_trip;
	logic low_active;
	logic wdt_normal;
	logic wdt_idle;
	logic full_req;
	logic level_req;
	logic tmr_clr;
	logic tmr_en;
	logic tmr_done;
	logic [TW-1:0] tmr_lim;
	logic [TW-1:0] startup_lim;
	logic rc_clock;
	logic to_ff;
	logic pd_ff;
	logic set_to;
	logic set_pd;
	logic clr_to;
	logic clr_pd;
	logic halt_cmd;
	logic ack_ff;
	logic bus_req;
	logic wr_hit;
	logic [31:0] rd_ff;
	logic [31:0] rd_mux;
	logic init_full;
	logic init_idle;

	// ==========================================================
	// Input synchronisers
	rsq_sync2 #(
		.RST_VAL(1'b0)
	) u_pin_sync (
		.mclk_in(mclk_in),
		.srst_in(srst_in),
		.async_in(ext_reset_pin_n_in),
		.sync_out(pin_n_sync)
	);

	rsq_sync2 #(
		.RST_VAL(1'b0)
	) u_low_sync (
		.mclk_in(mclk_in),
		.srst_in(srst_in),
		.async_in(low_supply_in),
		.sync_out(low_sync)
	);

	assign pin_low = ~pin_n_sync;

	// ==========================================================
	// Low supply qualification
	// Config gates the detector so a disabled option never resets
	assign low_active = low_sync & cfg_ff[`RSQ_CFG_LOW_EN];

	rsq_count #(
		.W(QW)
	) u_low_qual (
		.mclk_in(mclk_in),
		.srst_in(srst_in),
		.clr_in(~low_active),
		.en_in(low_active),
		.limit_in(QUAL_LIM),
		.done_out(low_qual_done)
	);

	// Trips only once the low level outlasts the qualify window
	assign low_trip = low_qual_done & low_active;

	assign low_supply_enable_out = cfg_ff[`RSQ_CFG_LOW_EN];
	assign low_supply_threshold_out = cfg_ff[`RSQ_CFG_THR_LSB +: 2];

	// ==========================================================
	// Request classification
	assign wdt_normal = wdt_timeout_in & ~sleep_mode_in;
	assign wdt_idle = wdt_timeout_in & sleep_mode_in;
	assign level_req = pin_low | low_trip;
	assign full_req = level_req | wdt_normal;

	// ==========================================================
	// Startup timer length
	assign osc_sel = rsq_pkg::rsq_osc_e'(cfg_ff[`RSQ_CFG_OSC_LSB +: 2]);
	assign rc_clock = (osc_sel == rsq_pkg::OSC_EXT_RC) || (osc_sel == rsq_pkg::OSC_INT_RC);
	// Crystals always need the long count to settle
	assign startup_lim = (rc_clock && cfg_ff[`RSQ_CFG_STARTUP_SHORT]) ? STARTUP_SHORT_LIM
		: STARTUP_LONG_LIM;

	assign tmr_lim = (state_ff == rsq_pkg::ST_DELAY) ? DELAY_LIM : startup_lim;
	assign tmr_en = (state_ff == rsq_pkg::ST_DELAY) || (state_ff == rsq_pkg::ST_STARTUP);
	assign tmr_clr = (nxt_state != state_ff);

	rsq_count #(
		.W(TW)
	) u_seq_timer (
		.mclk_in(mclk_in),
		.srst_in(srst_in),
		.clr_in(tmr_clr),
		.en_in(tmr_en),
		.limit_in(tmr_lim),
		.done_out(tmr_done)
	);

	// ==========================================================
	// Sequencer
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			rsq_pkg::ST_RUN:
			begin
				if (full_req)
					nxt_state = rsq_pkg::ST_HOLD;
				else if (wdt_idle)
					nxt_state = rsq_pkg::ST_STARTUP;
			end
			rsq_pkg::ST_HOLD:
			begin
				if (!level_req)
					nxt_state = rsq_pkg::ST_DELAY;
			end
			rsq_pkg::ST_DELAY:
			begin
				if (level_req)
					nxt_state = rsq_pkg::ST_HOLD;
				else if (tmr_done)
					nxt_state = rsq_pkg::ST_STARTUP;
			end
			rsq_pkg::ST_STARTUP:
			begin
				if (level_req)
					nxt_state = rsq_pkg::ST_HOLD;
				else if (tmr_done)
					nxt_state = rsq_pkg::ST_INIT;
			end
			rsq_pkg::ST_INIT:
			begin
				if (full_req)
					nxt_state = rsq_pkg::ST_HOLD;
				else
					nxt_state = rsq_pkg::ST_RUN;
			end
			default:
			begin
				nxt_state = rsq_pkg::ST_HOLD;
			end
		endcase
	end

	// Power-on starts in the hold state so the release delay runs
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			state_ff <= rsq_pkg::ST_HOLD;
		else
			state_ff <= nxt_state;
	end

	// Remembers whether the sequence in progress is a full reset
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			full_ff <= 1'b1;
		else if (nxt_state == rsq_pkg::ST_HOLD)
			full_ff <= 1'b1;
		else if ((state_ff == rsq_pkg::ST_RUN) && wdt_idle)
			full_ff <= 1'b0;
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			por_ff <= 1'b1;
		else if (state_ff == rsq_pkg::ST_INIT)
			por_ff <= 1'b0;
	end

	// ==========================================================
	// Cause record
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			cause_ff <= rsq_pkg::CAUSE_POR;
		else if ((state_ff == rsq_pkg::ST_RUN) || (state_ff == rsq_pkg::ST_INIT))
		begin
			// Power-on is never overwritten until it has completed
			if (por_ff)
				cause_ff <= rsq_pkg::CAUSE_POR;
			else if (pin_low)
				cause_ff <= rsq_pkg::CAUSE_PIN;
			else if (low_trip)
				cause_ff <= rsq_pkg::CAUSE_LOW;
			else if (wdt_normal)
				cause_ff <= rsq_pkg::CAUSE_WDT;
			else if (wdt_idle && (state_ff == rsq_pkg::ST_RUN))
				cause_ff <= rsq_pkg::CAUSE_WDT_IDLE;
		end
	end

	// ==========================================================
	// Core reset
	// Asserted straight from the request, released only from a flop
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			hold_ff <= 1'b1;
		else
			// In run only a live full request raises it, so an idle wake stays quiet
			hold_ff <= (full_ff && (state_ff != rsq_pkg::ST_RUN)) ? (nxt_state != rsq_pkg::ST_RUN)
				: full_req;
	end

	assign core_reset_out = hold_ff | full_req;

	// ==========================================================
	// Reset flags
	// Pin or low supply masks a coincident watchdog event
	assign set_to = (state_ff == rsq_pkg::ST_RUN) && !por_ff && !level_req
		&& wdt_timeout_in;
	assign set_pd = (state_ff == rsq_pkg::ST_RUN) && !por_ff && !level_req
		&& wdt_idle;
	assign clr_to = wr_hit && (avs_address_in == `RSQ_STAT_OFS)
		&& avs_writedata_in[`RSQ_STAT_TO];
	assign clr_pd = wr_hit && (avs_address_in == `RSQ_STAT_OFS)
		&& avs_writedata_in[`RSQ_STAT_PD];
	assign halt_cmd = wr_hit && (avs_address_in == `RSQ_CTRL_OFS)
		&& avs_writedata_in[`RSQ_CTRL_HALT];

	// Power-on clears both flags through the sync reset
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			to_ff <= 1'b0;
		else if (set_to)
			to_ff <= 1'b1;
		else if (clr_to)
			to_ff <= 1'b0;
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			pd_ff <= 1'b0;
		else if (set_pd || halt_cmd)
			pd_ff <= 1'b1;
		else if (clr_pd)
			pd_ff <= 1'b0;
	end

	assign timeout_flag_out = to_ff;
	assign power_down_flag_out = pd_ff;

	// ==========================================================
	// Initialisation strobes
	assign init_full = (state_ff == rsq_pkg::ST_INIT) && full_ff;
	assign init_idle = (state_ff == rsq_pkg::ST_INIT) && !full_ff;

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			pc_zero_out <= 1'b0;
			sp_zero_out <= 1'b0;
			sp_top_out <= 1'b0;
			irq_disable_out <= 1'b0;
			wdt_clear_out <= 1'b0;
			timer_off_out <= 1'b0;
			prescaler_clear_out <= 1'b0;
			io_input_out <= 1'b0;
			wake_out <= 1'b0;
		end
		else
		begin
			pc_zero_out <= init_full | init_idle;
			sp_zero_out <= init_idle;
			sp_top_out <= init_full;
			irq_disable_out <= init_full;
			wdt_clear_out <= init_full | init_idle;
			timer_off_out <= init_full;
			prescaler_clear_out <= init_full;
			io_input_out <= init_full;
			wake_out <= init_idle;
		end
	end

	// ==========================================================
	// Avalon-MM slave
	// Every access takes exactly one wait cycle
	assign bus_req = (avs_read_in | avs_write_in) & ~ack_ff;
	assign avs_waitrequest_out = bus_req;
	assign wr_hit = avs_write_in & ack_ff & avs_byteenable_in[0];

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			ack_ff <= 1'b0;
		else
			ack_ff <= bus_req;
	end

	always_comb
	begin
		rd_mux = 32'h0;
		case (avs_address_in)
			`RSQ_CFG_OFS:
			begin
				rd_mux[5:0] = cfg_ff;
			end
			`RSQ_STAT_OFS:
			begin
				rd_mux[`RSQ_STAT_TO] = to_ff;
				rd_mux[`RSQ_STAT_PD] = pd_ff;
				rd_mux[`RSQ_STAT_LOW] = low_sync;
				rd_mux[`RSQ_STAT_CAUSE_LSB +: 3] = cause_ff;
				rd_mux[`RSQ_STAT_BUSY] = state_ff != rsq_pkg::ST_RUN;
			end
			default:
			begin
				rd_mux = 32'h0;
			end
		endcase
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			rd_ff <= 32'h0;
		else if (avs_read_in && bus_req)
			rd_ff <= rd_mux;
	end

	assign avs_readdata_out = rd_ff;

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			cfg_ff <= `RSQ_CFG_RST;
		else if (wr_hit && (avs_address_in == `RSQ_CFG_OFS))
			cfg_ff <= avs_writedata_in[5:0];
	end

endmodule

// ### sim/rsq_properties.sv
`timescale 1ns/1ps
module rsq_properties #(
	parameter int RELEASE_DELAY_CYC = 20,
	parameter int QUALIFY_CYC = 5
)
(
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic ext_reset_pin_n_in,
	input wire logic low_supply_in,
	input wire logic wdt_timeout_in,
	input wire logic sleep_mode_in,
	input wire logic low_supply_enable_out,
	input wire logic core_reset_out,
	input wire logic pc_zero_out,
	input wire logic sp_zero_out,
	input wire logic sp_top_out,
	input wire logic irq_disable_out,
	input wire logic wdt_clear_out,
	input wire logic timer_off_out,
	input wire logic prescaler_clear_out,
	input wire logic io_input_out,
	input wire logic wake_out,
	input wire logic timeout_flag_out,
	input wire logic power_down_flag_out
);
	// ==========================================================
	// Run lengths of reset, low supply and pin high
	logic [15:0] hi_ff, lo_ff;
	logic [3:0] ph_ff;
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			hi_ff <= 16'h0;
			lo_ff <= 16'h0;
			ph_ff <= 4'h0;
		end
		else
		begin
			hi_ff <= core_reset_out ? hi_ff + 16'h1 : 16'h0;
			lo_ff <= low_supply_in ? lo_ff + 16'h1 : 16'h0;
			ph_ff <= ext_reset_pin_n_in ? ph_ff + {3'h0, ph_ff != 4'hf} : 4'h0;
		end
	end
	// ==========================================================
	// Properties
	default clocking dc @(posedge mclk_in); endclocking
	default disable iff (srst_in);
	sequence s_idle_wdt;
		wdt_timeout_in && sleep_mode_in && !core_reset_out;
	endsequence
	sequence s_idle_quiet;
		timeout_flag_out && power_down_flag_out && !core_reset_out ##1 !core_reset_out [*3];
	endsequence
	chk_pin_reset: assert property (!ext_reset_pin_n_in [*3] |-> core_reset_out)
		else $error("pin low did not reset");
	chk_release_delay: assert property ($fell(core_reset_out) |-> hi_ff >= RELEASE_DELAY_CYC + 2)
		else $error("reset released too early");
	chk_supply_qualify: assert property ($rose(core_reset_out) && ph_ff > 4'h4
		&& !wdt_timeout_in && !$past(wdt_timeout_in)
		|-> low_supply_enable_out && lo_ff > QUALIFY_CYC)
		else $error("low supply reset not qualified");
	chk_wdt_normal: assert property (!core_reset_out ##1
		wdt_timeout_in && !sleep_mode_in |-> core_reset_out ##1 timeout_flag_out && core_reset_out)
		else $error("normal watchdog did not reset");
	chk_wdt_idle: assert property (s_idle_wdt |=> s_idle_quiet)
		else $error("idle watchdog flags or reset wrong");
	chk_idle_strobes: assert property (sp_zero_out
		|-> pc_zero_out && wdt_clear_out && wake_out && !sp_top_out && !core_reset_out)
		else $error("idle strobes wrong");
	chk_full_strobes: assert property (sp_top_out |-> pc_zero_out && wdt_clear_out
		&& irq_disable_out && timer_off_out && prescaler_clear_out && io_input_out && !wake_out)
		else $error("full reset strobes wrong");
	chk_por_flags: assert property ($fell(srst_in)
		|-> !timeout_flag_out && !power_down_flag_out && core_reset_out)
		else $error("power-on flags wrong");
	chk_level_flags: assert property ($rose(core_reset_out) && !wdt_timeout_in
		&& !$past(wdt_timeout_in) |=> $stable(timeout_flag_out) && $stable(power_down_flag_out))
		else $error("pin or supply reset changed flags");
endmodule

bind rsq_top rsq_properties #(.RELEASE_DELAY_CYC(RELEASE_DELAY_CYC), .QUALIFY_CYC(QUALIFY_CYC))
	u_chk (.*);

// ### sim/rsq_pin_model.sv
`timescale 1ns/1ps
module rsq_pin_model #(
	parameter int RC_CYC = 3
)
(
	input wire logic mclk_in,
	input wire logic press_in,
	output logic pin_n_out
);
	int n = 0;
	// Pull-up through the RC: the pin recovers only after the capacitor charges
	initial pin_n_out = 1'b1;
	always @(posedge mclk_in)
	begin
		if (press_in)
		begin
			n <= RC_CYC;
			pin_n_out <= 1'b0;
		end
		else if (n > 0)
			n <= n - 1;
		else
			pin_n_out <= 1'b1;
	end
endmodule

// ### sim/testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam int D = 20;
	localparam int Q = 5;
	logic mclk_in = 1'b0, srst_in = 1'b1, low_supply_in = 1'b0, wdt_timeout_in = 1'b0;
	logic sleep_mode_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0, press = 1'b0;
	logic [3:0] avs_address_in = 4'h0, avs_byteenable_in = 4'h0;
	logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, q;
	logic ext_reset_pin_n_in, avs_waitrequest_out, low_supply_enable_out, core_reset_out;
	logic [1:0] low_supply_threshold_out;
	logic pc_zero_out, sp_zero_out, sp_top_out, irq_disable_out, wdt_clear_out, timer_off_out;
	logic prescaler_clear_out, io_input_out, wake_out, timeout_flag_out, power_down_flag_out;
	logic [8:0] seen = 9'h0;
	logic seen_clr = 1'b0;
	int n_fail = 0, n_checks = 0, n;
	typedef struct packed {logic [3:0] a; logic [31:0] d; logic [3:0] be; logic [31:0] e;} rsq_row_s;
	rsq_row_s rows [4] = '{'{4'h0, 32'h2b, 4'hf, 32'h2b}, '{4'h0, 32'h3f, 4'h0, 32'h2b},
		'{4'hc, 32'hff, 4'hf, 32'h0}, '{4'h0, 32'h23, 4'hf, 32'h23}};

	always #12.5 mclk_in = ~mclk_in;
	// Sticky record of init strobes, they last one cycle only
	always @(posedge mclk_in)
		seen <= seen_clr ? 9'h0 : seen | {pc_zero_out, sp_zero_out, sp_top_out, irq_disable_out,
			wdt_clear_out, timer_off_out, prescaler_clear_out, io_input_out, wake_out};

	rsq_top #(.RELEASE_DELAY_CYC(D), .QUALIFY_CYC(Q)) u_dut (.*);
	rsq_pin_model u_pin (.mclk_in(mclk_in), .press_in(press), .pin_n_out(ext_reset_pin_n_in));

	// ==========================================================
	// Tasks
	task automatic print_verdict();
		$display("checks=%0d fails=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] r);
		int i;
		@(posedge mclk_in);
		avs_read_in <= !w;
		avs_write_in <= w;
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_byteenable_in <= be;
		i = 0;
		do
		begin
			@(posedge mclk_in);
			i++;
		end
		while (avs_waitrequest_out !== 1'b0 && i < 50);
		if (i >= 50)
		begin
			n_fail++;
			print_verdict();
		end
		r = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
	endtask

	task automatic wfall(output int c);
		c = 0;
		do begin @(negedge mclk_in); c++; end while (core_reset_out !== 1'b0 && c < 3000);
		if (c >= 3000)
		begin
			n_fail++;
			print_verdict();
		end
	endtask

	// Source k: 0 pin, 1 watchdog, 2 low supply; s is the start-up count
	task automatic run_rst(input int k, input int s);
		int c;
		@(posedge mclk_in);
		seen_clr <= 1'b1;
		@(posedge mclk_in);
		seen_clr <= 1'b0;
		press <= (k == 0);
		wdt_timeout_in <= (k == 1);
		low_supply_in <= (k == 2);
		@(posedge mclk_in);
		wdt_timeout_in <= 1'b0;
		repeat (k == 0 ? 3 : k == 2 ? 20 : 0) @(posedge mclk_in);
		press <= 1'b0;
		low_supply_in <= 1'b0;
		@(negedge mclk_in);
		chk(core_reset_out, 1'b1);
		wfall(c);
		chk(c + 1 >= D + s && c + 1 <= D + s + 12, 1);
		repeat (2) @(posedge mclk_in);
		chk(seen, 9'h17e);
		$display("test reset source %0d done", k);
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (10) @(posedge mclk_in);
		srst_in <= 1'b0;
		wfall(n);
		chk(n >= D + 1024 && n <= D + 1036, 1);
		repeat (2) @(posedge mclk_in);
		chk(seen, 9'h17e);
		chk({timeout_flag_out, power_down_flag_out}, 2'b00);
		$display("test power-on done");
		foreach (rows[i])
		begin
			bus(1'b1, rows[i].a, rows[i].d, rows[i].be, q);
			bus(1'b0, rows[i].a, 32'h0, 4'hf, q);
			chk(q, rows[i].e);
		end
		chk({low_supply_threshold_out, low_supply_enable_out}, 3'h3);
		$display("test registers done");
		@(posedge mclk_in);
		seen_clr <= 1'b1;
		@(posedge mclk_in);
		seen_clr <= 1'b0;
		sleep_mode_in <= 1'b1;
		wdt_timeout_in <= 1'b1;
		@(posedge mclk_in);
		wdt_timeout_in <= 1'b0;
		repeat (20) @(posedge mclk_in);
		sleep_mode_in <= 1'b0;
		chk(seen, 9'h191);
		bus(1'b0, 4'h4, 32'h0, 4'hf, q);
		chk(q & 32'h3b, 32'h2b);
		$display("test idle watchdog done");
		run_rst(0, 2);
		bus(1'b0, 4'h4, 32'h0, 4'hf, q);
		chk(q & 32'h3b, 32'h13);
		bus(1'b1, 4'h4, 32'h3, 4'hf, q);
		run_rst(1, 2);
		chk({timeout_flag_out, power_down_flag_out}, 2'b10);
		// Short pulse while enabled, then long pulse while disabled
		for (int i = 0; i < 2; i++)
		begin
			bus(1'b1, 4'h0, i ? 32'h22 : 32'h23, 4'hf, q);
			low_supply_in <= 1'b1;
			repeat (i ? 20 : Q - 2) @(posedge mclk_in);
			low_supply_in <= 1'b0;
			repeat (10) @(posedge mclk_in);
			@(negedge mclk_in);
			chk(core_reset_out, 1'b0);
		end
		bus(1'b1, 4'h0, 32'h23, 4'hf, q);
		run_rst(2, 2);
		chk({timeout_flag_out, power_down_flag_out}, 2'b10);
		bus(1'b1, 4'h0, 32'h31, 4'hf, q);
		run_rst(1, 1024);
		bus(1'b1, 4'h0, 32'h39, 4'hf, q);
		run_rst(1, 1024);
		srst_in <= 1'b1;
		repeat (10) @(posedge mclk_in);
		srst_in <= 1'b0;
		@(negedge mclk_in);
		chk({core_reset_out, timeout_flag_out, power_down_flag_out}, 3'h4);
		$display("test mid-run reset done");
		print_verdict();
	end
endmodule
